// File: verilog/dch_top.sv
// Command interface of a four-drive disk controller
`default_nettype none
// How it works
// R1: Host writes interrupt vector before requests.
// R2: Host loads pointer-table base during initialisation.
// R3: Table entry n selects drive n block.
// R4: Drive control fields are read, never written.
// R5: Current cylinder only written, never read.
// R6: Static command fields untouched during command.
// R7: Dynamic fields updated after every sector.
// R8: Host loads and validates fields beforehand.
// R9: Status updated per transfer, cleared on accept.
// R10: Host leaves block alone until completion.
// R11: Main status byte kept current for polling.
// R12: Fetch parameters first, write results last.
// R13: Block accesses go through the DMA port.
// R14: Four drives, served one after another.
// R15: Internal bus users run strictly one at a time.
// R16: DMA and disk sides asynchronous to control. Only disk-side inputs are synchronised; DMA_ACK is used directly.
// R17: Serial transfer excludes others once buffer DMA.
// R18: Work scheduled as five logical operations.
// R19: Host requests by setting drive start bit.
// R20: Host should share service fairly.
// R21: Lowest pending drive number served first.
// R22: Other drive pends; same drive answered busy.
// R23: Invalid command, options or retries terminate.
// R24: Reset clears state and idles everything.
// R25: No start before vector and base written.
module dch_top #(
	parameter int SECTOR_BYTES = 256
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Register port
	input wire logic [dch_pkg::ADDR_W-1:0] ADDR,
	input wire logic [dch_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [dch_pkg::DATA_W-1:0] RDATA,
	// Parameter block DMA
	output logic DMA_REQ,
	output logic DMA_WRITE,
	output logic [31:0] DMA_ADDR,
	output logic [31:0] DMA_WDATA,
	input wire logic DMA_ACK,
	input wire logic [31:0] DMA_RDATA,
	// Interrupt request
	output logic IRQ,
	output logic [7:0] IRQ_VECTOR,
	output logic [1:0] IRQ_DRIVE,
	output logic [7:0] IRQ_STATUS,
	// Drive side
	output logic SEEK_GO,
	output logic [15:0] SEEK_CYL,
	input wire logic SEEK_DONE,
	output logic DISK_GO,
	output logic [7:0] DISK_CMD,
	output logic [1:0] DISK_DRIVE,
	output logic [15:0] DISK_SECTOR,
	input wire logic DISK_DONE,
	input wire logic DISK_ERR,
	input wire logic BUF_DMA_REQ,
	output logic BUF_DMA_GNT
);
	dch_pkg::dch_state_type state, next_state;
	logic [1:0] active, next_active, low_idx;
	logic [3:0] pending, next_pending, s1, s2, s3, rise;
	logic abort, next_abort;
	logic [7:0] vec, next_vec, stat, next_stat, settle, next_settle, irq_st, next_irq_st;
	logic [15:0] base_hi, next_base_hi, base_lo, next_base_lo;
	logic [2:0] init, next_init, idx, next_idx;
	logic [31:0] blk_base, next_blk_base, cmd, next_cmd, bufadr, next_bufadr;
	logic [15:0] count, next_count, target, next_target, sector, next_sector, drvctl, next_drvctl;
	logic dma_pend, next_dma_pend, dma_we, next_dma_we, irq, next_irq;
	logic [31:0] dma_addr, next_dma_addr, dma_wdata, next_dma_wdata;
	logic seek_go, next_seek_go, disk_go, next_disk_go;
	logic [4:0] tick_cnt, next_tick_cnt;
	logic [15:0] rdata, next_rdata;
	logic [3:0] gnt, req;
	logic ack, slow_req, in_service, init_done, cmd_valid;
	logic ln, ln_we, go_fin;
	logic [3:0] ln_word;
	logic [31:0] ln_base, ln_data;
	logic [7:0] fin_bits;

	if (dch_pkg::TICK_CYCLES < 1 || dch_pkg::TICK_CYCLES > 31 || SECTOR_BYTES < 1) begin : g_check
		$error("dch_top timing or sector size out of range");
	end

	function automatic logic [3:0] fetch_word(input logic [2:0] i);
		case (i)
			3'h0: fetch_word = dch_pkg::BLK_CMD;
			3'h1: fetch_word = dch_pkg::BLK_COUNT;
			3'h2: fetch_word = dch_pkg::BLK_TARGET;
			3'h3: fetch_word = dch_pkg::BLK_SECTOR;
			3'h4: fetch_word = dch_pkg::BLK_BUF;
			default: fetch_word = dch_pkg::BLK_DRVCTL;
		endcase
	endfunction

	// Disk side runs on its own timing, so its inputs are synchronised
	always_ff @(posedge CLK or negedge RESET_N) begin // R16
		if (!RESET_N) begin
			s1 <= 4'h0;
			s2 <= 4'h0;
			s3 <= 4'h0;
		end else begin
			s1 <= {BUF_DMA_REQ, DISK_ERR, DISK_DONE, SEEK_DONE};
			s2 <= s1;
			s3 <= s2;
		end
	end
	assign rise = s2 & ~s3;

	assign req = {dma_pend, s2[3], slow_req, WR | RD};
	dch_bus_arb #(.REQS(4)) u_arb (
		.clk(CLK),
		.reset_n(RESET_N),
		.req(req),
		.gnt(gnt)
	);
	assign DMA_REQ = dma_pend & gnt[dch_pkg::BUS_BLK]; // R13
	assign ack = DMA_REQ & DMA_ACK;
	assign BUF_DMA_GNT = gnt[dch_pkg::BUS_BUF]; // R17
	assign in_service = state != dch_pkg::S_IDLE;
	assign init_done = &init;
	assign cmd_valid = (cmd[7:0] == dch_pkg::CMD_READ || cmd[7:0] == dch_pkg::CMD_WRITE ||
		cmd[7:0] == dch_pkg::CMD_FORMAT || cmd[7:0] == dch_pkg::CMD_SEEK) &&
		(cmd[15:8] & dch_pkg::OPT_ILLEGAL) == 8'h00 && cmd[23:16] <= dch_pkg::MAX_RETRY;

	always_comb begin
		next_state = state;
		next_active = active;
		next_pending = pending;
		next_abort = abort;
		next_vec = vec;
		next_stat = stat;
		next_settle = settle;
		next_irq_st = irq_st;
		next_base_hi = base_hi;
		next_base_lo = base_lo;
		next_init = init;
		next_idx = idx;
		next_blk_base = blk_base;
		next_cmd = cmd;
		next_bufadr = bufadr;
		next_count = count;
		next_target = target;
		next_sector = sector;
		next_drvctl = drvctl;
		next_dma_pend = dma_pend & ~ack;
		next_dma_we = dma_we;
		next_dma_addr = dma_addr;
		next_dma_wdata = dma_wdata;
		next_irq = 1'b0;
		next_seek_go = 1'b0;
		next_disk_go = 1'b0;
		next_tick_cnt = 5'h0;
		next_rdata = 16'h0;
		slow_req = 1'b0;
		ln = 1'b0;
		ln_we = 1'b0;
		ln_word = dch_pkg::BLK_STAT;
		ln_base = blk_base;
		ln_data = 32'h0;
		go_fin = 1'b0;
		fin_bits = 8'h00;
		low_idx = 2'h0;
		for (int d = dch_pkg::DRIVES - 1; d >= 0; d--) begin
			if (pending[d]) begin
				low_idx = 2'(d); // R21
			end
		end
		// Register reads, answered in the following cycle
		if (RD) begin
			case (ADDR)
				dch_pkg::REG_VECTOR: next_rdata = {8'h00, vec};
				dch_pkg::REG_BASE_HI: next_rdata = base_hi;
				dch_pkg::REG_BASE_LO: next_rdata = base_lo;
				dch_pkg::REG_CONFIG: next_rdata = {7'h00, abort, 4'h0, pending};
				dch_pkg::REG_STATUS: next_rdata = {pending, init_done, in_service, active, stat}; // R11
				default: next_rdata = 16'h0;
			endcase
		end
		unique case (state)
			dch_pkg::S_IDLE: begin
				if (init_done && pending != 4'h0) begin // R25
					next_active = low_idx; // R14
					next_pending[low_idx] = 1'b0;
					next_abort = 1'b0;
					next_stat = 8'h00;
					next_idx = 3'h0;
					ln = 1'b1;
					ln_base = {base_hi, base_lo};
					ln_word = {2'b00, low_idx}; // R3
					next_state = dch_pkg::S_PTR;
				end
			end
			dch_pkg::S_PTR: begin
				if (ack) begin
					next_blk_base = DMA_RDATA;
					ln = 1'b1;
					ln_base = DMA_RDATA;
					ln_word = fetch_word(3'h0); // R12
					next_state = dch_pkg::S_FETCH;
				end
			end
			dch_pkg::S_FETCH: begin
				if (ack) begin
					case (idx)
						3'h0: next_cmd = DMA_RDATA;
						3'h1: next_count = DMA_RDATA[15:0];
						3'h2: next_target = DMA_RDATA[15:0];
						3'h3: next_sector = DMA_RDATA[15:0];
						3'h4: next_bufadr = DMA_RDATA;
						default: next_drvctl = DMA_RDATA[15:0]; // R4
					endcase
					if (idx == dch_pkg::FETCH_LAST) begin
						next_state = dch_pkg::S_CHECK;
					end else begin
						next_idx = idx + 3'h1;
						ln = 1'b1;
						ln_word = fetch_word(idx + 3'h1);
					end
				end
			end
			dch_pkg::S_CHECK: begin
				if (cmd_valid) begin
					ln = 1'b1;
					ln_we = 1'b1; // R9
					next_state = dch_pkg::S_CLEAR;
				end else begin
					go_fin = 1'b1; // R23
					fin_bits[dch_pkg::STB_INVALID] = 1'b1;
				end
			end
			dch_pkg::S_CLEAR: begin
				if (ack) begin
					next_stat[dch_pkg::STB_ACTIVE] = 1'b1;
					next_idx = 3'h0;
					next_state = dch_pkg::S_SEEK; // R18
				end
			end
			dch_pkg::S_SEEK: begin
				if (idx == 3'h0) begin
					slow_req = 1'b1;
					if (gnt[dch_pkg::BUS_SLOW]) begin // R15
						next_seek_go = 1'b1;
						next_idx = 3'h1;
					end
				end else if (rise[0]) begin
					next_settle = drvctl[7:0]; // R4
					next_state = dch_pkg::S_SETTLE;
				end
			end
			dch_pkg::S_SETTLE: begin
				next_tick_cnt = tick_cnt + 5'h1;
				if (tick_cnt == 5'(dch_pkg::TICK_CYCLES - 1)) begin
					next_tick_cnt = 5'h0;
				end
				if (settle == 8'h00) begin
					ln = 1'b1;
					ln_we = 1'b1;
					ln_word = dch_pkg::BLK_CYL; // R5
					ln_data = {16'h0, target};
					next_state = dch_pkg::S_CYL;
				end else if (tick_cnt == 5'(dch_pkg::TICK_CYCLES - 1)) begin
					next_settle = settle - 8'h1;
				end
			end
			dch_pkg::S_CYL: begin
				if (ack) begin
					if (cmd[7:0] == dch_pkg::CMD_SEEK || count == 16'h0 || abort) begin
						go_fin = 1'b1;
						fin_bits[dch_pkg::STB_DONE] = 1'b1;
						fin_bits[dch_pkg::STB_ABORT] = abort;
					end else begin
						next_idx = 3'h0;
						next_state = dch_pkg::S_XFER;
					end
				end
			end
			dch_pkg::S_XFER: begin
				if (idx == 3'h0) begin
					next_disk_go = 1'b1;
					next_idx = 3'h1;
				end else if (rise[1]) begin
					if (s2[2]) begin
						go_fin = 1'b1;
						fin_bits[dch_pkg::STB_DISKERR] = 1'b1;
					end else begin
						next_sector = sector + 16'h1; // R7
						next_bufadr = bufadr + 32'(SECTOR_BYTES);
						next_count = count - 16'h1;
						next_idx = 3'h0;
						ln = 1'b1;
						ln_we = 1'b1;
						ln_word = dch_pkg::BLK_SECTOR;
						ln_data = {16'h0, sector + 16'h1};
						next_state = dch_pkg::S_UPDATE;
					end
				end
			end
			dch_pkg::S_UPDATE: begin
				if (ack) begin
					next_idx = idx + 3'h1;
					if (idx == 3'h0) begin
						ln = 1'b1;
						ln_we = 1'b1;
						ln_word = dch_pkg::BLK_BUF; // R7
						ln_data = bufadr;
					end else if (idx == 3'h1) begin
						ln = 1'b1;
						ln_we = 1'b1;
						ln_data = {24'h0, stat}; // R9
					end else if (count == 16'h0 || abort || cmd[7:0] == dch_pkg::CMD_FORMAT) begin
						go_fin = 1'b1;
						fin_bits[dch_pkg::STB_DONE] = 1'b1;
						fin_bits[dch_pkg::STB_ABORT] = abort;
					end else begin
						next_idx = 3'h0;
						next_state = dch_pkg::S_XFER;
					end
				end
			end
			dch_pkg::S_FINAL: begin
				if (ack) begin
					next_irq = 1'b1; // R12
					next_irq_st = stat;
					next_state = dch_pkg::S_IDLE;
				end
			end
			default: next_state = dch_pkg::S_IDLE;
		endcase
		if (go_fin) begin
			next_stat = (stat & 8'h10) | fin_bits;
			ln = 1'b1;
			ln_we = 1'b1;
			ln_data = {24'h0, (stat & 8'h10) | fin_bits};
			next_state = dch_pkg::S_FINAL;
		end
		if (ln) begin
			next_dma_pend = 1'b1;
			next_dma_we = ln_we;
			next_dma_addr = ln_base + {26'h0, ln_word, 2'b00};
			next_dma_wdata = ln_data;
		end
		// Register writes; a host set wins over the hardware clear
		if (WR) begin
			case (ADDR)
				dch_pkg::REG_VECTOR: begin
					next_vec = WDATA[7:0]; // R1
					next_init[0] = 1'b1;
				end
				dch_pkg::REG_BASE_HI: begin
					next_base_hi = WDATA; // R2
					next_init[1] = 1'b1;
				end
				dch_pkg::REG_BASE_LO: begin
					next_base_lo = WDATA;
					next_init[2] = 1'b1;
				end
				dch_pkg::REG_CONFIG: begin
					for (int d = 0; d < dch_pkg::DRIVES; d++) begin
						if (WDATA[d] && in_service && active == 2'(d)) begin
							next_stat[dch_pkg::STB_BUSY] = 1'b1; // R22
							next_irq = 1'b1;
							next_irq_st = stat | 8'h10;
						end else if (WDATA[d]) begin
							next_pending[d] = 1'b1; // R19
						end
					end
					if (WDATA[dch_pkg::CFG_ABORT] && in_service) begin
						next_abort = 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	// Reset clears every register and leaves the bus idle
	always_ff @(posedge CLK or negedge RESET_N) begin // R24
		if (!RESET_N) begin
			state <= dch_pkg::S_IDLE;
			active <= 2'h0;
			pending <= 4'h0;
			abort <= 1'b0;
			vec <= 8'h00;
			stat <= 8'h00;
			settle <= 8'h00;
			irq_st <= 8'h00;
			base_hi <= 16'h0;
			base_lo <= 16'h0;
			init <= 3'h0;
			idx <= 3'h0;
			blk_base <= 32'h0;
			cmd <= 32'h0;
			bufadr <= 32'h0;
			count <= 16'h0;
			target <= 16'h0;
			sector <= 16'h0;
			drvctl <= 16'h0;
			dma_pend <= 1'b0;
			dma_we <= 1'b0;
			dma_addr <= 32'h0;
			dma_wdata <= 32'h0;
			irq <= 1'b0;
			seek_go <= 1'b0;
			disk_go <= 1'b0;
			tick_cnt <= 5'h0;
			rdata <= 16'h0;
		end else begin
			state <= next_state;
			active <= next_active;
			pending <= next_pending;
			abort <= next_abort;
			vec <= next_vec;
			stat <= next_stat;
			settle <= next_settle;
			irq_st <= next_irq_st;
			base_hi <= next_base_hi;
			base_lo <= next_base_lo;
			init <= next_init;
			idx <= next_idx;
			blk_base <= next_blk_base;
			cmd <= next_cmd;
			bufadr <= next_bufadr;
			count <= next_count;
			target <= next_target;
			sector <= next_sector;
			drvctl <= next_drvctl;
			dma_pend <= next_dma_pend;
			dma_we <= next_dma_we;
			dma_addr <= next_dma_addr;
			dma_wdata <= next_dma_wdata;
			irq <= next_irq;
			seek_go <= next_seek_go;
			disk_go <= next_disk_go;
			tick_cnt <= next_tick_cnt;
			rdata <= next_rdata;
		end
	end

	assign RDATA = rdata;
	assign DMA_WRITE = dma_we;
	assign DMA_ADDR = dma_addr;
	assign DMA_WDATA = dma_wdata;
	assign IRQ = irq;
	assign IRQ_VECTOR = vec;
	assign IRQ_DRIVE = active;
	assign IRQ_STATUS = irq_st;
	assign SEEK_GO = seek_go;
	assign SEEK_CYL = target;
	assign DISK_GO = disk_go;
	assign DISK_CMD = cmd[7:0];
	assign DISK_DRIVE = active;
	assign DISK_SECTOR = sector;

	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	a_start_gated: assert property (state == dch_pkg::S_IDLE && !init_done |=> state == dch_pkg::S_IDLE) // R25
		else $error("command started before initialisation");
	a_lowest_drive: assert property (state == dch_pkg::S_IDLE && init_done && pending != 4'h0
		|=> state == dch_pkg::S_PTR && active == $past(low_idx)) // R21
		else $error("pending drive not lowest first");
	a_busy_reject: assert property (WR && ADDR == dch_pkg::REG_CONFIG && in_service && WDATA[active]
		|=> IRQ && IRQ_STATUS[dch_pkg::STB_BUSY] && stat[dch_pkg::STB_BUSY]) // R22
		else $error("request for active drive not answered busy");
	a_ptr_entry: assert property (DMA_REQ && state == dch_pkg::S_PTR
		|-> DMA_ADDR == {base_hi, base_lo} + {28'h0, active, 2'b00} && !DMA_WRITE) // R3
		else $error("pointer entry read at wrong address");
	a_write_fields: assert property (DMA_REQ && DMA_WRITE |-> DMA_ADDR == blk_base + 32'h10 ||
		DMA_ADDR == blk_base + 32'h0c || DMA_ADDR == blk_base + 32'h14 || DMA_ADDR == blk_base + 32'h18) // R4 R6
		else $error("write to a host-owned parameter field");
	a_cyl_unread: assert property (DMA_REQ && !DMA_WRITE && state != dch_pkg::S_PTR
		|-> DMA_ADDR != blk_base + 32'h10) // R5
		else $error("current cylinder read");
	a_status_clear: assert property (state == dch_pkg::S_CLEAR && DMA_REQ |-> DMA_WRITE && DMA_WDATA == 32'h0) // R9
		else $error("status not cleared on accept");
	a_invalid_end: assert property (state == dch_pkg::S_CHECK && !cmd_valid
		|=> state == dch_pkg::S_FINAL && stat[dch_pkg::STB_INVALID] ##[1:1000] IRQ) // R23
		else $error("invalid command not terminated");
	a_sector_update: assert property (state == dch_pkg::S_XFER && idx == 3'h1 && rise[1] && !s2[2]
		|=> state == dch_pkg::S_UPDATE && sector == $past(sector) + 16'h1) // R7
		else $error("dynamic fields not advanced after sector");
	a_bus_exclusive: assert property (BUF_DMA_GNT |-> !DMA_REQ && !WR && !RD) // R17
		else $error("buffer transfer overlaps another bus user");
	a_seek_granted: assert property (seek_go |-> $past(gnt[dch_pkg::BUS_SLOW])) // R15
		else $error("drive control issued without the bus");
endmodule
`default_nettype wire

// File: inc/dch_pkg.sv
// Constants and types for the disk controller command interface
`default_nettype none
package dch_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int DRIVES = 4;
	// Register byte offsets
	localparam logic [7:0] REG_VECTOR = 8'h00;
	localparam logic [7:0] REG_BASE_HI = 8'h04;
	localparam logic [7:0] REG_BASE_LO = 8'h08;
	localparam logic [7:0] REG_CONFIG = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam int CFG_ABORT = 8;
	// Parameter block word offsets, four bytes per word
	localparam logic [3:0] BLK_CMD = 4'h0;
	localparam logic [3:0] BLK_COUNT = 4'h1;
	localparam logic [3:0] BLK_TARGET = 4'h2;
	localparam logic [3:0] BLK_SECTOR = 4'h3;
	localparam logic [3:0] BLK_CYL = 4'h4;
	localparam logic [3:0] BLK_BUF = 4'h5;
	localparam logic [3:0] BLK_STAT = 4'h6;
	localparam logic [3:0] BLK_DRVCTL = 4'h8;
	localparam logic [2:0] FETCH_LAST = 3'h5;
	// Command word fields and checks
	localparam logic [7:0] CMD_READ = 8'h01;
	localparam logic [7:0] CMD_WRITE = 8'h02;
	localparam logic [7:0] CMD_FORMAT = 8'h03;
	localparam logic [7:0] CMD_SEEK = 8'h04;
	localparam logic [7:0] OPT_ILLEGAL = 8'hf0;
	localparam logic [7:0] MAX_RETRY = 8'h0f;
	// Main status byte bits
	localparam int STB_DONE = 0;
	localparam int STB_INVALID = 1;
	localparam int STB_DISKERR = 2;
	localparam int STB_ABORT = 3;
	localparam int STB_BUSY = 4;
	localparam int STB_ACTIVE = 7;
	// Internal data bus users, index 0 wins
	localparam int BUS_REG = 0;
	localparam int BUS_SLOW = 1;
	localparam int BUS_BUF = 2;
	localparam int BUS_BLK = 3;
	// Settling time unit
	localparam int CLK_NS = 50;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_PTR = 4'h1, S_FETCH = 4'h2, S_CHECK = 4'h3, S_CLEAR = 4'h4, S_SEEK = 4'h5,
		S_SETTLE = 4'h6, S_CYL = 4'h7, S_XFER = 4'h8, S_UPDATE = 4'h9, S_FINAL = 4'ha
	} dch_state_type;
endpackage
`default_nettype wire

// File: verilog/dch_bus_arb.sv
// One-at-a-time arbiter for the internal data bus
`default_nettype none
module dch_bus_arb #(
	parameter int REQS = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Requests and grants
	input wire logic [REQS-1:0] req,
	output logic [REQS-1:0] gnt
);
	logic [REQS-1:0] hold;
	logic [REQS-1:0] next_hold;

	if (REQS < 2) begin : g_check
		$error("dch_bus_arb needs at least two users");
	end

	// Register access is never made to wait; a holder just stalls that cycle
	always_comb begin
		gnt = '0;
		if (req[0]) begin
			gnt[0] = 1'b1;
		end else if ((hold & req) != '0) begin
			gnt = hold & req;
		end else begin
			for (int i = REQS - 1; i > 0; i--) begin
				if (req[i]) begin
					gnt = '0;
					gnt[i] = 1'b1;
				end
			end
		end
		next_hold = (req[0] ? hold : gnt) & ~{{(REQS-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hold <= '0;
		end else begin
			hold <= next_hold;
		end
	end

	a_one_grant: assert property (@(posedge clk) disable iff (!reset_n) $onehot0(gnt)) // R15
		else $error("more than one bus user granted");
endmodule
`default_nettype wire

// File: test/dch_host_model.sv
// Stand-in for host memory behind the DMA port and for the drives
`default_nettype none
module dch_host_model #(
	parameter int ACK_WAIT = 2,
	parameter int DRV_WAIT = 6
) (
	// Clock
	input wire logic clk,
	// Parameter block DMA
	input wire logic dma_req,
	input wire logic dma_write,
	input wire logic [31:0] dma_addr,
	input wire logic [31:0] dma_wdata,
	output logic dma_ack,
	output logic [31:0] dma_rdata,
	// Drive side
	input wire logic seek_go,
	input wire logic disk_go,
	output logic seek_done,
	output logic disk_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [256];
	int rd_cnt [256];
	int wr_cnt [256];
	int wait_cnt = 0;
	int seek_t = 0;
	int disk_t = 0;
	logic [31:0] junk = 32'h0;
	// Read data only means something beside ack; junk moves every cycle
	assign dma_ack = dma_req && (wait_cnt >= ACK_WAIT);
	assign dma_rdata = dma_ack ? mem[dma_addr[9:2]] : junk;
	initial begin
		seek_done = 1'h0;
		disk_done = 1'h0;
	end
	always @(posedge clk) begin
		junk <= junk + 32'h9e37_79b9;
		if (dma_ack) begin
			wait_cnt <= 0;
			if (dma_write) begin
				mem[dma_addr[9:2]] <= dma_wdata;
				wr_cnt[dma_addr[9:2]] <= wr_cnt[dma_addr[9:2]] + 1;
			end else begin
				rd_cnt[dma_addr[9:2]] <= rd_cnt[dma_addr[9:2]] + 1;
			end
		end else if (dma_req) begin
			wait_cnt <= wait_cnt + 1;
		end
		if (seek_go) begin
			seek_done <= 1'h0;
			seek_t <= DRV_WAIT;
		end else if (seek_t > 0) begin
			seek_t <= seek_t - 1;
			seek_done <= (seek_t == 1);
		end
		if (disk_go) begin
			disk_done <= 1'h0;
			disk_t <= DRV_WAIT;
		end else if (disk_t > 0) begin
			disk_t <= disk_t - 1;
			disk_done <= (disk_t == 1);
		end
	end
endmodule
`default_nettype wire

// File: test/dch_top_tb.sv
// Self-checking bench for the disk command interface
`default_nettype none
module dch_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [1:0] drv;
		logic [31:0] w0;
		logic [31:0] cnt;
		logic [31:0] xfers;
		logic inval;
		logic err;
	} dch_row_type;
	localparam int SB = 64;
	localparam logic [31:0] TBL = 32'h40;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr_s = 1'h0;
	logic rd_s = 1'h0;
	logic disk_err = 1'h0;
	logic buf_req = 1'h0;
	logic buf_on = 1'h0;
	logic [15:0] rdata, seek_cyl, v, cyl;
	logic dma_req, dma_write, dma_ack, irq, seek_go, seek_done, disk_go, disk_done, buf_gnt;
	logic [31:0] dma_addr, dma_wdata, dma_rdata;
	logic [7:0] irq_vector, irq_status, st, disk_cmd;
	logic [1:0] disk_drive;
	logic [15:0] disk_sector, dsec;
	logic [9:0] dcmd;
	logic [1:0] irq_drive;
	int error_cnt = 0;
	int compares = 0;
	int seeks, gos, dma_cyc, gnts, tick;
	dch_row_type rows [8] = '{
		'{2'h0, 32'h0003_0001, 32'h2, 32'h2, 1'h0, 1'h0},
		'{2'h1, 32'h0000_0002, 32'h1, 32'h1, 1'h0, 1'h1},
		'{2'h2, 32'h0000_0003, 32'h5, 32'h1, 1'h0, 1'h0},
		'{2'h3, 32'h0000_0004, 32'h3, 32'h0, 1'h0, 1'h0},
		'{2'h0, 32'h0000_0007, 32'h1, 32'h0, 1'h1, 1'h0},
		'{2'h1, 32'h0000_1001, 32'h1, 32'h0, 1'h1, 1'h0},
		'{2'h2, 32'h0010_0001, 32'h1, 32'h0, 1'h1, 1'h0},
		'{2'h3, 32'h000f_0001, 32'h0, 32'h0, 1'h0, 1'h0}
	};
	dch_top #(.SECTOR_BYTES(SB)) dut (
		.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
		.DMA_REQ(dma_req), .DMA_WRITE(dma_write), .DMA_ADDR(dma_addr), .DMA_WDATA(dma_wdata),
		.DMA_ACK(dma_ack), .DMA_RDATA(dma_rdata), .IRQ(irq), .IRQ_VECTOR(irq_vector), .IRQ_DRIVE(irq_drive),
		.IRQ_STATUS(irq_status), .SEEK_GO(seek_go), .SEEK_CYL(seek_cyl), .SEEK_DONE(seek_done),
		.DISK_GO(disk_go), .DISK_CMD(disk_cmd), .DISK_DRIVE(disk_drive), .DISK_SECTOR(disk_sector),
		.DISK_DONE(disk_done),
		.DISK_ERR(disk_err), .BUF_DMA_REQ(buf_req), .BUF_DMA_GNT(buf_gnt)
	);
	dch_host_model #(.ACK_WAIT(2), .DRV_WAIT(6)) hm (
		.clk(clk), .dma_req(dma_req), .dma_write(dma_write), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
		.dma_ack(dma_ack), .dma_rdata(dma_rdata), .seek_go(seek_go), .disk_go(disk_go),
		.seek_done(seek_done), .disk_done(disk_done)
	);
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (error_cnt == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'h1;
		@(posedge clk);
		wr_s <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		addr <= a;
		rd_s <= 1'h1;
		@(posedge clk);
		rd_s <= 1'h0;
		#1 v = rdata;
		@(posedge clk);
	endtask
	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (n > lim) begin
				chk(32'h0, 32'h1);
				report_and_stop();
			end
		end while (irq !== 1'h1);
		st = irq_status;
	endtask
	task automatic prep(input dch_row_type r);
		int e;
		e = 64 + 16 * r.drv;
		hm.mem[e] = r.w0;
		hm.mem[e + 1] = r.cnt;
		hm.mem[e + 2] = {30'h40, r.drv};
		hm.mem[e + 3] = 32'h20;
		hm.mem[e + 4] = 32'hdead;
		hm.mem[e + 5] = 32'h1000;
		hm.mem[e + 6] = 32'hffff_ffff;
		hm.mem[e + 8] = 32'h2;
		for (int i = 0; i < 256; i++) begin
			hm.rd_cnt[i] = 0;
			hm.wr_cnt[i] = 0;
		end
		seeks = 0;
		gos = 0;
		disk_err <= r.err;
	endtask
	task automatic check(input dch_row_type r);
		int e;
		e = 64 + 16 * r.drv;
		chk(32'(irq_drive), 32'(r.drv));
		chk(32'(irq_vector), 32'h5a);
		chk(32'(st[dch_pkg::STB_INVALID]), 32'(r.inval));
		chk(32'(st[dch_pkg::STB_DISKERR]), 32'(r.err));
		chk(gos, r.xfers);
		chk(hm.wr_cnt[e] + hm.wr_cnt[e + 1] + hm.wr_cnt[e + 2] + hm.wr_cnt[e + 8], 32'h0);
		chk(hm.rd_cnt[e + 4], 32'h0);
		chk(hm.rd_cnt[16 + r.drv], 32'h1);
		chk(hm.wr_cnt[e + 6], r.inval ? 32'h1 : r.xfers + 32'h2 - 32'(r.err));
		if (!r.inval) begin
			chk(32'(st[dch_pkg::STB_DONE]), 32'(!r.err));
			chk(seeks, 32'h1);
			chk(32'(cyl), {30'h40, r.drv});
			chk(hm.mem[e + 4], {30'h40, r.drv});
		end else begin
			chk(seeks, 32'h0);
		end
		if (r.xfers != 32'h0) begin
			chk(32'(dcmd), {22'h0, r.w0[7:0], r.drv});
			chk(32'(dsec), 32'h20 + r.xfers - 32'h1);
		end
		if (!r.err) begin
			chk(hm.mem[e + 3], 32'h20 + r.xfers);
			chk(hm.mem[e + 5], 32'h1000 + r.xfers * SB);
		end
		rd(dch_pkg::REG_STATUS);
		chk(32'({v[11:10], v[7:0]}), {22'h0, 2'h2, st});
	endtask
	// Bus sharing watch; buffer requests come in short bursts so the block DMA is not starved
	always @(posedge clk) begin
		tick++;
		buf_req <= buf_on && (tick % 8 < 2);
		if (seek_go === 1'h1) begin
			seeks++;
			cyl = seek_cyl;
		end
		if (disk_go === 1'h1) begin
			gos++;
			dcmd = {disk_cmd, disk_drive};
			dsec = disk_sector;
		end
		if (dma_req === 1'h1) dma_cyc++;
		if (buf_gnt === 1'h1) gnts++;
		if ((dma_req & (buf_gnt | wr_s | rd_s)) !== 1'h0 || (buf_gnt & (wr_s | rd_s)) !== 1'h0) chk(32'h1, 32'h0);
	end
	initial begin
		#5000000;
		chk(32'h0, 32'h1);
		report_and_stop();
	end
	initial begin
		int n;
		for (int d = 0; d < 4; d++) hm.mem[16 + d] = 32'h100 + 32'(d) * 32'h40;
		repeat (6) @(posedge clk);
		reset_n <= 1'h1;
		@(posedge clk);
		wr(dch_pkg::REG_VECTOR, 16'h005a);
		wr(dch_pkg::REG_BASE_HI, 16'h0000);
		wr(dch_pkg::REG_BASE_LO, TBL[15:0]);
		for (int i = 0; i < 8; i++) begin
			prep(rows[i]);
			wr(dch_pkg::REG_CONFIG, 16'h1 << rows[i].drv);
			wait_irq(3000);
			check(rows[i]);
		end
		rd(8'hfc);
		chk(32'(v), 32'h0);
		// Reset in the middle of a command
		prep(rows[0]);
		wr(dch_pkg::REG_CONFIG, 16'h0001);
		n = 0;
		while (dma_req !== 1'h1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		chk(32'(dma_req), 32'h1);
		reset_n <= 1'h0;
		#1 chk(32'({dma_req, irq, seek_go, disk_go, buf_gnt, rdata}), 32'h0);
		repeat (6) @(posedge clk);
		reset_n <= 1'h1;
		@(posedge clk);
		rd(dch_pkg::REG_STATUS);
		chk(32'(v), 32'h0);
		rd(dch_pkg::REG_VECTOR);
		chk(32'(v), 32'h0);
		// Start before setup is complete must wait
		prep(rows[3]);
		dma_cyc = 0;
		wr(dch_pkg::REG_CONFIG, 16'h0008);
		wr(dch_pkg::REG_VECTOR, 16'h005a);
		wr(dch_pkg::REG_BASE_HI, 16'h0000);
		repeat (30) @(posedge clk);
		chk(dma_cyc, 32'h0);
		wr(dch_pkg::REG_BASE_LO, TBL[15:0]);
		wait_irq(3000);
		check(rows[3]);
		// Pending order and busy answer, with buffer DMA competing
		prep(rows[2]);
		prep(rows[3]);
		prep(rows[0]);
		buf_on <= 1'h1;
		wr(dch_pkg::REG_CONFIG, 16'h0001);
		wr(dch_pkg::REG_CONFIG, 16'h000d);
		// Busy pulse stands in the cycle that ends as the write task returns
		st = irq_status;
		chk(32'({irq, irq_drive, st[dch_pkg::STB_BUSY]}), 32'h9);
		rd(dch_pkg::REG_STATUS);
		chk(32'(v[15:12]), 32'hc);
		for (int k = 0; k < 3; k++) begin
			wait_irq(5000);
			chk(32'(irq_drive), k == 0 ? 32'h0 : 32'(k + 1));
		end
		chk(32'(gnts > 0), 32'h1);
		report_and_stop();
	end
endmodule
`default_nettype wire
